// ==== design/fsrl_pkg.sv ====
// constants and types shared by the flash status register logic
package fsrl_pkg;

   // status byte one field positions
   localparam int unsigned ONE_LOCK_BIT = 7;
   localparam int unsigned ONE_ERR_BIT = 5;
   localparam int unsigned ONE_WPP_BIT = 4;
   localparam int unsigned ONE_SWP_HI = 3;
   localparam int unsigned ONE_SWP_LO = 2;
   localparam int unsigned ONE_WEL_BIT = 1;
   localparam int unsigned ONE_BUSY_BIT = 0;

   // status byte two field positions
   localparam int unsigned TWO_RESET_CMD_ENABLE_BIT = 4;
   localparam int unsigned TWO_SLE_BIT = 3;
   localparam int unsigned TWO_PS_BIT = 2;
   localparam int unsigned TWO_ES_BIT = 1;
   localparam int unsigned TWO_BUSY_BIT = 0;

   // power-up values of the stored bits
   localparam logic LOCK_RESET = 1'h0;
   localparam logic ERR_RESET = 1'h0;
   localparam logic WEL_RESET = 1'h0;
   localparam logic RESET_CMD_ENABLE_RESET = 1'h0;
   localparam logic SLE_RESET = 1'h0;
   localparam logic FROZEN_RESET = 1'h0;
   localparam logic WP_PIN_RESET = 1'h1;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // software protection summary codes
   localparam logic [1:0] SWP_NONE = 2'h0;
   localparam logic [1:0] SWP_SOME = 2'h1;
   localparam logic [1:0] SWP_ALL = 2'h3;

   // global protect/unprotect code field of the byte one write
   localparam int unsigned GLOBAL_HI = 5;
   localparam int unsigned GLOBAL_LO = 2;

   localparam int unsigned SECTOR_COUNT = 32;

   // commands gated by the write enable latch
   typedef enum logic [2:0] {
      CMD_PROGRAM,
      CMD_ERASE,
      CMD_PROTECT,
      CMD_UNPROTECT,
      CMD_LOCKDOWN,
      CMD_FREEZE,
      CMD_OTP_WRITE,
      CMD_CFG_WRITE
   } fsrl_cmd_t;

endpackage

// ==== design/fsrl_pin_sync.sv ====
// three-stage synchroniser with agreement filter for the write-protect pin
`timescale 1ns/1ps
module fsrl_pin_sync
   import fsrl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic pinIn,
   output logic pinLevel
);
   logic stageOneReg;
   logic stageTwoReg;
   logic stageThreeReg;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         stageOneReg <= WP_PIN_RESET;
         stageTwoReg <= WP_PIN_RESET;
         stageThreeReg <= WP_PIN_RESET;
      end else begin
         stageOneReg <= pinIn;
         stageTwoReg <= stageOneReg;
         stageThreeReg <= stageTwoReg;
      end
   end

   // level only moves once the two settled stages agree
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         pinLevel <= WP_PIN_RESET;
      end else if (stageTwoReg == stageThreeReg) begin
         pinLevel <= stageThreeReg;
      end
   end
endmodule // fsrl_pin_sync

// ==== design/fsrl_prot_summary.sv ====
// reduces the per-sector protection bits to the two-bit summary code
`timescale 1ns/1ps
module fsrl_prot_summary
   import fsrl_pkg::*;
#(
   parameter int unsigned SECTORS = SECTOR_COUNT
)
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [SECTORS-1:0] sectorProt,
   output logic [1:0] summary
);
   // power-up default of the sectors is all protected
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         summary <= SWP_ALL;
      end else if (&sectorProt) begin
         summary <= SWP_ALL;
      end else if (|sectorProt) begin
         summary <= SWP_SOME;
      end else begin
         summary <= SWP_NONE;
      end
   end
endmodule // fsrl_prot_summary

// ==== design/fsrl_status_regs.sv ====
// status register bytes one and two with their command gating
`timescale 1ns/1ps
module fsrl_status_regs
   import fsrl_pkg::*;
#(
   parameter int unsigned SECTORS = SECTOR_COUNT
)
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic wpPinN,
   input wire logic [SECTORS-1:0] sectorProt,
   input wire logic writeEnableCmd,
   input wire logic writeDisableCmd,
   input wire logic statusWrite1Req,
   input wire logic statusWrite2Req,
   input wire logic [7:0] statusData,
   input wire logic frameOk,
   input wire logic swResetReq,
   input wire logic gatedCmdReq,
   input wire fsrl_cmd_t cmdKind,
   input wire logic gatedOpEnd,
   input wire logic holdAbort,
   input wire logic opFinish,
   input wire logic opFail,
   input wire logic busyIn,
   input wire logic progSuspIn,
   input wire logic eraseSuspIn,
   output logic [7:0] statusByteOne,
   output logic [7:0] statusByteTwo,
   output logic cmdGrant,
   output logic cmdDeny,
   output logic resetGrant,
   output logic globalProtGo,
   output logic [3:0] globalProtCode,
   output logic lockdownFrozen
);
   logic lockReg;
   logic errReg;
   logic welReg;
   logic rsteReg;
   logic sleReg;
   logic frozenReg;
   logic wpLevel;
   logic wpAsserted;
   logic [1:0] swpCode;
   logic grantNow;
   logic resetTake;
   logic wr1Take;
   logic wr2Take;
   logic wpBlock;
   logic freezeGrant;
   logic welClear;

   fsrl_pin_sync u_wp_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .pinIn(wpPinN),
      .pinLevel(wpLevel)
   );

   fsrl_prot_summary #(
      .SECTORS(SECTORS)
   ) u_summary (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .sectorProt(sectorProt),
      .summary(swpCode)
   );

   assign wpAsserted = !wpLevel;

   // gating of the latch-protected commands
   always_comb begin
      grantNow = 1'b0;
      case (cmdKind)
         CMD_PROTECT, CMD_UNPROTECT: begin
            grantNow = welReg && !lockReg;
         end
         CMD_LOCKDOWN, CMD_FREEZE: begin
            grantNow = welReg && sleReg;
         end
         default: begin
            grantNow = welReg;
         end
      endcase
   end

   assign resetTake = swResetReq && frameOk && rsteReg;
   assign wr1Take = statusWrite1Req && frameOk && welReg;
   assign wr2Take = statusWrite2Req && frameOk && welReg;
   // clearing the lock while the pin is asserted blocks the lock update and the global change; the code is still taken
   assign wpBlock = wpAsserted && !statusData[ONE_LOCK_BIT];
   assign freezeGrant = gatedCmdReq && grantNow && (cmdKind == CMD_FREEZE);

   // partial or unknown opcodes never reach these strobes, so the latch holds
   assign welClear = writeDisableCmd
      || gatedOpEnd
      || (gatedCmdReq && !grantNow)
      || holdAbort
      || statusWrite1Req
      || statusWrite2Req
      || resetTake;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         welReg <= WEL_RESET;
      end else if (writeEnableCmd) begin
         welReg <= 1'b1;
      end else if (welClear) begin
         welReg <= 1'b0;
      end
   end

   // reset command leaves the lock alone
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         lockReg <= LOCK_RESET;
      end else if (wr1Take && !wpBlock) begin
         lockReg <= statusData[ONE_LOCK_BIT];
      end
   end

   // global change is judged on the lock state before the write
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         globalProtGo <= 1'b0;
         globalProtCode <= 4'h0;
      end else begin
         globalProtGo <= wr1Take && !wpBlock && !lockReg;
         if (wr1Take) begin
            globalProtCode <= statusData[GLOBAL_HI:GLOBAL_LO];
         end
      end
   end

   // only completed operations report; aborts never raise opFinish
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         errReg <= ERR_RESET;
      end else if (opFinish) begin
         errReg <= opFail;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rsteReg <= RESET_CMD_ENABLE_RESET;
      end else if (wr2Take) begin
         rsteReg <= statusData[TWO_RESET_CMD_ENABLE_BIT];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         frozenReg <= FROZEN_RESET;
      end else if (freezeGrant) begin
         frozenReg <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sleReg <= SLE_RESET;
      end else if (frozenReg || freezeGrant) begin
         sleReg <= 1'b0;
      end else if (wr2Take) begin
         sleReg <= statusData[TWO_SLE_BIT];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         cmdGrant <= 1'b0;
         cmdDeny <= 1'b0;
         resetGrant <= 1'b0;
         lockdownFrozen <= FROZEN_RESET;
      end else begin
         cmdGrant <= gatedCmdReq && grantNow;
         cmdDeny <= gatedCmdReq && !grantNow;
         resetGrant <= resetTake;
         lockdownFrozen <= frozenReg || freezeGrant;
      end
   end

   // both bytes rebuilt every cycle so polling always sees fresh values
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         statusByteOne <= BYTE_RESET;
         statusByteTwo <= BYTE_RESET;
      end else begin
         statusByteOne <= BYTE_RESET;
         statusByteOne[ONE_LOCK_BIT] <= lockReg;
         statusByteOne[ONE_ERR_BIT] <= errReg;
         statusByteOne[ONE_WPP_BIT] <= wpLevel;
         statusByteOne[ONE_SWP_HI:ONE_SWP_LO] <= swpCode;
         statusByteOne[ONE_WEL_BIT] <= welReg;
         statusByteOne[ONE_BUSY_BIT] <= busyIn;
         statusByteTwo <= BYTE_RESET;
         statusByteTwo[TWO_RESET_CMD_ENABLE_BIT] <= rsteReg;
         statusByteTwo[TWO_SLE_BIT] <= sleReg;
         statusByteTwo[TWO_PS_BIT] <= progSuspIn;
         statusByteTwo[TWO_ES_BIT] <= eraseSuspIn;
         statusByteTwo[TWO_BUSY_BIT] <= busyIn;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   property p_reset_ignored;
      swResetReq && !rsteReg |=> !resetGrant;
   endproperty
   a_reset_ignored: assert property (p_reset_ignored) else $error("reset taken while disabled");

   property p_lockdown_gate;
      gatedCmdReq && (cmdKind == CMD_LOCKDOWN) && !sleReg |=> cmdDeny && !cmdGrant;
   endproperty
   a_lockdown_gate: assert property (p_lockdown_gate) else $error("lockdown ran while disabled");

   property p_suspend_flags;
      ##1 statusByteTwo[TWO_PS_BIT] == $past(progSuspIn)
         && statusByteTwo[TWO_ES_BIT] == $past(eraseSuspIn);
   endproperty
   a_suspend_flags: assert property (p_suspend_flags) else $error("suspend flags stale");

   property p_reserved_two;
      statusByteTwo[7:5] == 3'h0;
   endproperty
   a_reserved_two: assert property (p_reserved_two) else $error("byte two reserved bits set");

   property p_protect_locked;
      gatedCmdReq && (cmdKind == CMD_PROTECT || cmdKind == CMD_UNPROTECT) && lockReg
         |=> cmdDeny && !welReg;
   endproperty
   a_protect_locked: assert property (p_protect_locked) else $error("protect passed the lock");

   property p_wp_hold_lock;
      wpAsserted && lockReg |=> lockReg;
   endproperty
   a_wp_hold_lock: assert property (p_wp_hold_lock) else $error("lock cleared under pin");

   property p_wel_gate;
      gatedCmdReq && !welReg |=> cmdDeny && !cmdGrant;
   endproperty
   a_wel_gate: assert property (p_wel_gate) else $error("gated command without latch");

   property p_reset_wel;
      resetTake && !writeEnableCmd |=> !welReg ##1 !statusByteOne[ONE_WEL_BIT];
   endproperty
   a_reset_wel: assert property (p_reset_wel) else $error("latch survived reset");

   property p_error_set;
      opFinish && opFail |=> ##1 statusByteOne[ONE_ERR_BIT];
   endproperty
   a_error_set: assert property (p_error_set) else $error("error flag missed");

   property p_reset_cmd_enable_stable;
      !wr2Take |=> $stable(rsteReg);
   endproperty
   a_reset_cmd_enable_stable: assert property (p_reset_cmd_enable_stable) else $error("reset enable moved");

   property p_frozen_sle;
      lockdownFrozen |-> !sleReg ##1 !statusByteTwo[TWO_SLE_BIT];
   endproperty
   a_frozen_sle: assert property (p_frozen_sle) else $error("lockdown enable after freeze");

   property p_busy_twin;
      statusByteOne[ONE_BUSY_BIT] == statusByteTwo[TWO_BUSY_BIT];
   endproperty
   a_busy_twin: assert property (p_busy_twin) else $error("busy copies differ");

   property p_wdis_clear;
      writeDisableCmd && !writeEnableCmd |=> !welReg;
   endproperty
   a_wdis_clear: assert property (p_wdis_clear) else $error("latch survived disable");

   property p_hold_clear;
      holdAbort && !writeEnableCmd |=> !welReg;
   endproperty
   a_hold_clear: assert property (p_hold_clear) else $error("latch survived hold abort");

   property p_err_abort;
      !opFinish |=> $stable(errReg);
   endproperty
   a_err_abort: assert property (p_err_abort) else $error("error flag moved without finish");

   property p_byte_two_bits;
      wr2Take && !frozenReg && !freezeGrant |=> rsteReg == $past(statusData[TWO_RESET_CMD_ENABLE_BIT])
         && sleReg == $past(statusData[TWO_SLE_BIT]);
   endproperty
   a_byte_two_bits: assert property (p_byte_two_bits) else $error("byte two write lost");

   property p_lock_reset_cmd;
      resetTake && !wr1Take |=> $stable(lockReg);
   endproperty
   a_lock_reset_cmd: assert property (p_lock_reset_cmd) else $error("reset moved the lock");

   property p_sle_reset_cmd;
      resetTake && !wr2Take && !freezeGrant |=> $stable(sleReg);
   endproperty
   a_sle_reset_cmd: assert property (p_sle_reset_cmd) else $error("reset moved lockdown");

   property p_global_lock;
      wr1Take && lockReg |=> !globalProtGo;
   endproperty
   a_global_lock: assert property (p_global_lock) else $error("global change while locked");

   property p_summary_code;
      statusByteOne[ONE_SWP_HI:ONE_SWP_LO] != 2'h2;
   endproperty
   a_summary_code: assert property (p_summary_code) else $error("reserved summary code");

   property p_busy_two;
      ##1 statusByteTwo[TWO_BUSY_BIT] == $past(busyIn);
   endproperty
   a_busy_two: assert property (p_busy_two) else $error("busy bit stale");

   c_reset_grant: cover property (resetGrant);
   c_freeze: cover property ($rose(lockdownFrozen));
   c_global: cover property (globalProtGo);
   c_wp_block: cover property (statusWrite1Req && frameOk && welReg && wpBlock);
   c_deny: cover property (cmdDeny);
endmodule // fsrl_status_regs

// ==== dv/fsrl_host_poll.sv ====
// host-side model that polls status byte one until busy falls
`timescale 1ns/1ps
module fsrl_host_poll
   import fsrl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic start,
   input wire logic [7:0] statusByteOne,
   output logic done
);
   logic poll_reg;
   logic lastBusy_reg;
   // a fresh byte each cycle; only a 1-to-0 edge ends the poll
   always_ff @(posedge ref_clk) begin
      if (!nrst || start) begin
         poll_reg <= start;
         lastBusy_reg <= 1'b0;
         done <= 1'b0;
      end else if (poll_reg) begin
         lastBusy_reg <= statusByteOne[ONE_BUSY_BIT];
         if (lastBusy_reg && !statusByteOne[ONE_BUSY_BIT]) begin
            done <= 1'b1;
            poll_reg <= 1'b0;
         end
      end
   end
endmodule // fsrl_host_poll

// ==== dv/tb.sv ====
// self-checking bench for the status register logic
`timescale 1ns/1ps
module tb
   import fsrl_pkg::*;
;
   localparam int WEN = 0, WDIS = 1, SW1 = 2, SW2 = 3, RST = 4, GAT = 5, OPE = 6;
   localparam int HLD = 7, FIN = 8;
   logic ref_clk = 0, nrst = 0, wpPinN = 1, frameOk = 1, opFail = 0;
   logic busyIn = 0, progSuspIn = 0, eraseSuspIn = 0, start = 0, done;
   logic [8:0] pl = '0;
   logic [31:0] sectorProt = '1;
   logic [7:0] statusData = 8'h00, b1, b2;
   fsrl_cmd_t cmdKind = CMD_PROGRAM;
   logic cmdGrant, cmdDeny, resetGrant, gG = 0, gD = 0, gR = 0;
   logic globalGo, lf, gP = 0;
   logic [3:0] gc;
   int n_errors = 0, n_compared = 0;
   always #10 ref_clk = ~ref_clk;
   fsrl_status_regs uut (.ref_clk(ref_clk), .nrst(nrst), .wpPinN(wpPinN),
      .sectorProt(sectorProt), .writeEnableCmd(pl[WEN]), .writeDisableCmd(pl[WDIS]),
      .statusWrite1Req(pl[SW1]), .statusWrite2Req(pl[SW2]), .statusData(statusData),
      .frameOk(frameOk), .swResetReq(pl[RST]), .gatedCmdReq(pl[GAT]), .cmdKind(cmdKind),
      .gatedOpEnd(pl[OPE]), .holdAbort(pl[HLD]), .opFinish(pl[FIN]), .opFail(opFail),
      .busyIn(busyIn), .progSuspIn(progSuspIn), .eraseSuspIn(eraseSuspIn),
      .statusByteOne(b1), .statusByteTwo(b2), .cmdGrant(cmdGrant), .cmdDeny(cmdDeny),
      .resetGrant(resetGrant), .globalProtGo(globalGo), .globalProtCode(gc),
      .lockdownFrozen(lf));
   fsrl_host_poll host (.ref_clk(ref_clk), .nrst(nrst), .start(start),
      .statusByteOne(b1), .done(done));
   // one-cycle answers are caught here so checks can come later
   always @(posedge ref_clk) begin
      if (cmdGrant === 1'b1) gG <= 1;
      if (cmdDeny === 1'b1) gD <= 1;
      if (resetGrant === 1'b1) gR <= 1;
      if (globalGo === 1'b1) gP <= 1;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         $display("wrong value at %0t: %s", $time, m);
         n_errors++;
      end
   endtask
   task automatic pulse(input int k, input logic [7:0] d = 8'h00,
                        input fsrl_cmd_t c = CMD_PROGRAM);
      @(negedge ref_clk);
      gG = 0; gD = 0; gR = 0; gP = 0;
      pl[k] = 1; statusData = d; cmdKind = c;
      @(negedge ref_clk);
      pl = '0;
      repeat (3) @(negedge ref_clk);
   endtask
   // write enable first, then the gated request
   task automatic wp(input int k, input logic [7:0] d = 8'h00,
                     input fsrl_cmd_t c = CMD_PROGRAM);
      pulse(WEN);
      pulse(k, d, c);
   endtask
   task automatic complete_run();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic t_byte_two();
      chk(b2, 8'h00, "byte two after reset");
      chk({b1[7], b1[5], b1[1]}, 8'h00, "byte one after reset");
      pulse(SW2, 8'hff);
      chk(b2, 8'h00, "write without latch");
      pulse(WEN);
      chk(b1[1], 1, "latch set");
      pulse(SW2, 8'hff);
      chk(b2, 8'h18, "byte two write");
      chk(b1[1], 0, "latch after write");
   endtask
   task automatic t_reset_cmd();
      wp(RST);
      chk(gR, 1, "reset enabled");
      chk(b1[1], 0, "latch after reset");
      chk(b2[4:3], 2'h3, "bits kept over reset");
      wp(SW2, 8'h08);
      pulse(RST);
      chk(gR, 0, "reset disabled");
   endtask
   task automatic t_gated();
      pulse(GAT, 8'h00, CMD_PROGRAM);
      chk(gD, 1, "gated without latch");
      wp(GAT, 8'h00, CMD_PROGRAM);
      chk(gG, 1, "gated grant");
      pulse(OPE);
      chk(b1[1], 0, "latch after op end");
      pulse(WEN);
      pulse(HLD);
      chk(b1[1], 0, "latch after hold");
      wp(GAT, 8'h00, CMD_LOCKDOWN);
      chk(gG, 1, "lockdown enabled");
      pulse(OPE);
      wp(SW2, 8'h10);
      wp(GAT, 8'h00, CMD_FREEZE);
      chk(gD, 1, "freeze disabled");
      wp(SW2, 8'h08);
      wp(GAT, 8'h00, CMD_FREEZE);
      chk(b2[3], 0, "frozen clears enable");
      chk(lf, 1, "freeze reported");
      wp(SW2, 8'h08);
      chk(b2[3], 0, "frozen stays clear");
   endtask
   task automatic t_lock();
      wp(SW1, 8'hff);
      chk({b1[7], b1[6], b1[5]}, 8'h04, "byte one write");
      chk(gP, 1, "global with lock open");
      chk(gc, 4'hf, "global code taken");
      wp(GAT, 8'h00, CMD_PROTECT);
      chk(gD, 1, "protect while locked");
      wp(GAT, 8'h00, CMD_UNPROTECT);
      chk(gD, 1, "unprotect while locked");
      wpPinN = 0;
      repeat (8) @(negedge ref_clk);
      chk(b1[4], 0, "pin asserted");
      wp(SW1, 8'h00);
      chk(b1[7], 1, "lock held by pin");
      chk(gP, 0, "no global under lock");
      wpPinN = 1;
      repeat (8) @(negedge ref_clk);
      wp(SW1, 8'h00);
      chk(b1[7], 0, "lock cleared");
   endtask
   task automatic t_err_sum();
      opFail = 1;
      pulse(FIN);
      chk(b1[5], 1, "error set");
      opFail = 0;
      pulse(FIN);
      chk(b1[5], 0, "error updated");
      opFail = 1;
      pulse(OPE);
      opFail = 0;
      chk(b1[5], 0, "abort keeps error clear");
      sectorProt = '0;
      repeat (6) @(negedge ref_clk);
      chk(b1[3:2], SWP_NONE, "none protected");
      sectorProt = 32'h1;
      repeat (6) @(negedge ref_clk);
      chk(b1[3:2], SWP_SOME, "some protected");
      sectorProt = '1;
      repeat (6) @(negedge ref_clk);
      chk(b1[3:2], SWP_ALL, "all protected");
   endtask
   task automatic t_busy();
      int i;
      busyIn = 1; progSuspIn = 1; eraseSuspIn = 1; start = 1;
      @(negedge ref_clk);
      start = 0;
      repeat (2) @(negedge ref_clk);
      chk({b1[0], b2[0]}, 8'h03, "busy in both bytes");
      chk(b2[2:1], 2'h3, "suspend flags");
      busyIn = 0; progSuspIn = 0; eraseSuspIn = 0;
      for (i = 0; i < 20 && done !== 1'b1; i++) @(negedge ref_clk);
      chk(done, 1, "poll sees ready");
      chk(b2, 8'h00, "byte two idle");
   endtask
   task automatic t_extra();
      pulse(WEN);
      pulse(WDIS);
      chk(b1[1], 0, "latch after disable");
      pulse(WEN);
      frameOk = 0;
      pulse(SW2, 8'h18);
      frameOk = 1;
      chk(b2[4], 0, "cut frame keeps reset enable");
      chk(b1[1], 0, "latch after cut write");
      wp(GAT, 8'h00, CMD_ERASE);
      chk(gG, 1, "erase granted");
      pulse(OPE);
      wp(GAT, 8'h00, CMD_UNPROTECT);
      chk(gG, 1, "unprotect with lock open");
      pulse(OPE);
   endtask
   initial begin
      repeat (20) @(negedge ref_clk);
      nrst = 1;
      repeat (8) @(negedge ref_clk);
      t_byte_two();
      t_reset_cmd();
      t_gated();
      t_lock();
      t_extra();
      t_err_sum();
      t_busy();
      complete_run();
   end
   // a hung run still ends in the closing report
   initial begin
      #1ms;
      n_errors++;
      complete_run();
   end
endmodule // tb
